/* File: common/sigma_delta_params.svh */
// Offsets, field positions, reset values and timing counts for the converter front end.
// Assumes a single 25 MHz clock; register indices are word indices (byte address = 4 x index).
`ifndef SIGMA_DELTA_PARAMS_SVH
`define SIGMA_DELTA_PARAMS_SVH

// Register indices
`define IDX_CONTROL_A        6'h00
`define IDX_REFERENCE_CTRL   6'h01
`define IDX_CONTROL_B        6'h02
`define IDX_EVENT_CONTROL    6'h04
`define IDX_IRQ_ENABLE_CLR   6'h05
`define IDX_IRQ_ENABLE_SET   6'h06
`define IDX_IRQ_FLAGS        6'h07
`define IDX_SEQ_STATUS       6'h08
`define IDX_INPUT_SELECT     6'h09
`define IDX_CONTROL_C        6'h0a
`define IDX_WINDOW_CONTROL   6'h0b
`define IDX_WINDOW_LOWER     6'h0c
`define IDX_WINDOW_UPPER     6'h10
`define IDX_OFFSET_CORR      6'h14
`define IDX_GAIN_CORR        6'h18
`define IDX_SHIFT_CORR       6'h1a
`define IDX_SOFTWARE_TRIGGER 6'h1c
`define IDX_SYNC_BUSY        6'h20
`define IDX_RESULT           6'h24
`define IDX_SEQ_CONTROL      6'h28
`define IDX_ANALOG_CONTROL   6'h2c

// Control A fields
`define CA_ON_REQUEST  7
`define CA_RUN_STANDBY 6
`define CA_ENABLE      1
`define CA_SOFT_RESET  0
`define CONTROL_A_RESET 8'h00

// Reference control fields
`define RC_BUFFER_ON   7
`define RC_SELECT_HI   1
`define RC_SELECT_LO   0

// Event control and software trigger fields
`define EV_START_INV   3
`define EV_FLUSH_INV   2
`define EV_START_EN    1
`define EV_FLUSH_EN    0
`define TRIG_START     1
`define TRIG_FLUSH     0

// Sync busy fields
`define SB_SOFT_RESET  0
`define SB_ENABLE      1

// Writable masks and reset values
`define MASK_CONTROL_A   32'h0000_00c3
`define MASK_REFERENCE   32'h0000_0083
`define MASK_CONTROL_B   32'h0000_f7ff
`define MASK_EVENT_CTRL  32'h0000_003f
`define MASK_IRQ_ENABLE  8'h07
`define MASK_INPUT_SEL   32'h0000_000f
`define MASK_BIT0        32'h0000_0001
`define MASK_WIN_MODE    32'h0000_0007
`define MASK_24BIT       32'h00ff_ffff
`define MASK_GAIN        32'h0000_3fff
`define MASK_SHIFT       32'h0000_000f
`define MASK_SEQ_CTRL    32'h0000_0007
`define MASK_ANALOG      32'h0000_00df
`define RESET_CONTROL_B  32'h0000_2000

// Bus responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

// Timing
`define CLK_PERIOD_NS    40
`define SYNC_CYCLES      4'd4
`define STARTUP_TIME_NS  2000
`define STARTUP_CYCLES   ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: common/sigma_delta_pkg.sv */
// Types shared by the converter front end.
// Assumes the constants of sigma_delta_params.svh.
package sigma_delta_pkg;

    typedef logic [5:0] reg_index_t;

    typedef enum logic [1:0] {
        RUN_OFF  = 2'b00,
        RUN_WAKE = 2'b01,
        RUN_ON   = 2'b10
    } run_state_t;

endpackage : sigma_delta_pkg

/* File: rtl/sync_tracker.sv */
// Tracks one write-synchronised operation crossing to the converter clock.
// Assumes the caller never starts a new operation while busy is high.
`timescale 1ns/10ps
`include "sigma_delta_params.svh"

module sync_tracker (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy_ff,
    output logic      done_ff
);

    logic [3:0] cnt_ff;
    wire        last = busy_ff && (cnt_ff == `SYNC_CYCLES - 4'd1);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            cnt_ff  <= 4'h0;
        end else begin
            done_ff <= last;
            if (start && !busy_ff) begin
                busy_ff <= 1'b1;
                cnt_ff  <= 4'h0;
            end else if (last) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end

endmodule : sync_tracker

/* File: rtl/converter_run_control.sv */
// Decides when the analog section is powered and when the converter runs.
// Assumes conv_done is a one-cycle pulse from the conversion engine.
`timescale 1ns/10ps
`include "sigma_delta_params.svh"

module converter_run_control (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic enabled,
    input  wire logic on_request_mode,
    input  wire logic keep_running_in_standby,
    input  wire logic standby_sleep,
    input  wire logic conv_request,
    input  wire logic conv_done,
    output logic      analog_on_ff,
    output logic      running_ff
);

    localparam logic [7:0] STARTUP_LAST = 8'(`STARTUP_CYCLES - 1);

    sigma_delta_pkg::run_state_t state_ff;
    sigma_delta_pkg::run_state_t nxt_state;
    logic [7:0]                  cnt_ff;

    // Standby halts the converter unless running in standby is allowed
    wire allowed = enabled && (!standby_sleep || keep_running_in_standby);
    // On-request mode wakes only when asked; otherwise runs continuously
    wire want    = allowed && (!on_request_mode || conv_request);
    wire wake_up = (cnt_ff == STARTUP_LAST);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sigma_delta_pkg::RUN_OFF: begin
                if (want)
                    nxt_state = sigma_delta_pkg::RUN_WAKE;
            end
            sigma_delta_pkg::RUN_WAKE: begin
                if (!allowed)
                    nxt_state = sigma_delta_pkg::RUN_OFF;
                else if (wake_up)
                    nxt_state = sigma_delta_pkg::RUN_ON;
            end
            sigma_delta_pkg::RUN_ON: begin
                if (!allowed)
                    nxt_state = sigma_delta_pkg::RUN_OFF;
                else if (on_request_mode && conv_done && !conv_request)
                    nxt_state = sigma_delta_pkg::RUN_OFF;
            end
            default: nxt_state = sigma_delta_pkg::RUN_OFF;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff     <= sigma_delta_pkg::RUN_OFF;
            cnt_ff       <= 8'h00;
            analog_on_ff <= 1'b0;
            running_ff   <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= (nxt_state == sigma_delta_pkg::RUN_WAKE && state_ff == sigma_delta_pkg::RUN_WAKE)
                            ? cnt_ff + 8'h01 : 8'h00;
            analog_on_ff <= (nxt_state != sigma_delta_pkg::RUN_OFF);
            running_ff   <= (nxt_state == sigma_delta_pkg::RUN_ON);
        end
    end

endmodule : converter_run_control

/* File: rtl/sigma_delta_adc_control_regs.sv */
// Register front end of the sigma-delta converter: AXI4-Lite slave, control A,
// reference control, the remaining register map, sync tracking and triggers.
// Assumes one 25 MHz clock; event and request inputs are synchronous to it.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "sigma_delta_params.svh"

////////////////////////////////////////////////////////////////////////////////
module sigma_delta_adc_control_regs (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // System and converter side
    input  wire logic        standby_sleep,
    input  wire logic        conv_request,
    input  wire logic        conv_done,
    input  wire logic [31:0] conversion_result,
    input  wire logic        start_event,
    input  wire logic        flush_event,
    output logic             analog_powered,
    output logic             converter_running,
    output logic             conversion_start,
    output logic             conversion_flush,
    output logic             reference_buffer_on,
    output logic [1:0]       reference_select
);

    ////////////////////////////////////////////////////////////////////////////
    // Writable bits of each plain storage word; zero means reserved or special
    function automatic logic [31:0] wr_mask(input sigma_delta_pkg::reg_index_t idx);
        if (idx == `IDX_REFERENCE_CTRL)       wr_mask = `MASK_REFERENCE;
        else if (idx == `IDX_CONTROL_B)       wr_mask = `MASK_CONTROL_B;
        else if (idx == `IDX_EVENT_CONTROL)   wr_mask = `MASK_EVENT_CTRL;
        else if (idx == `IDX_INPUT_SELECT)    wr_mask = `MASK_INPUT_SEL;
        else if (idx == `IDX_CONTROL_C)       wr_mask = `MASK_BIT0;
        else if (idx == `IDX_WINDOW_CONTROL)  wr_mask = `MASK_WIN_MODE;
        else if (idx == `IDX_WINDOW_LOWER)    wr_mask = `MASK_24BIT;
        else if (idx == `IDX_WINDOW_UPPER)    wr_mask = `MASK_24BIT;
        else if (idx == `IDX_OFFSET_CORR)     wr_mask = `MASK_24BIT;
        else if (idx == `IDX_GAIN_CORR)       wr_mask = `MASK_GAIN;
        else if (idx == `IDX_SHIFT_CORR)      wr_mask = `MASK_SHIFT;
        else if (idx == `IDX_SEQ_CONTROL)     wr_mask = `MASK_SEQ_CTRL;
        else if (idx == `IDX_ANALOG_CONTROL)  wr_mask = `MASK_ANALOG;
        else                                  wr_mask = 32'h0000_0000;
    endfunction : wr_mask

    function automatic logic [31:0] reset_value(input sigma_delta_pkg::reg_index_t idx);
        if (idx == `IDX_CONTROL_B) reset_value = `RESET_CONTROL_B;
        else                       reset_value = 32'h0000_0000;
    endfunction : reset_value

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0]  ctrl_a_ff;
    logic [31:0] word_ff [0:63];
    logic [2:0]  irq_enable_ff;
    logic        enabled_synced_ff;
    logic        start_prev_ff;
    logic        flush_prev_ff;
    logic        sw_busy;
    logic        sw_done;
    logic        en_busy;
    logic        en_done;

    // Bus channel state
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel acceptance; address and data may arrive in either order
    wire aw_take      = awvalid && awready;
    wire w_take       = wvalid && wready;
    wire do_write     = aw_held_ff && w_held_ff && !bvalid;
    wire nxt_aw_held  = (aw_held_ff || aw_take) && !do_write;
    wire nxt_w_held   = (w_held_ff || w_take) && !do_write;
    wire nxt_bvalid   = do_write || (bvalid && !bready);

    wire sigma_delta_pkg::reg_index_t wr_idx = awaddr_ff[7:2];
    wire [31:0] strb_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    wire        lane0     = wstrb_ff[0];

    // Control A write decode
    wire hit_ctrl_a   = do_write && (wr_idx == `IDX_CONTROL_A) && lane0;
    wire wr_soft_rst  = wdata_ff[`CA_SOFT_RESET];
    wire en_change    = wdata_ff[`CA_ENABLE] != ctrl_a_ff[`CA_ENABLE];
    wire ctrl_a_clash = wr_soft_rst ? sw_busy : (en_change && en_busy);
    wire start_sw     = hit_ctrl_a && wr_soft_rst && !sw_busy;
    wire ctrl_a_plain = hit_ctrl_a && !wr_soft_rst && !ctrl_a_clash && !sw_busy;
    wire start_en     = ctrl_a_plain && en_change;

    // Reference control is locked while the enable bit reads one
    wire ref_locked   = do_write && (wr_idx == `IDX_REFERENCE_CTRL) && lane0
                        && ctrl_a_ff[`CA_ENABLE];
    wire wr_reject    = (hit_ctrl_a && ctrl_a_clash) || ref_locked;
    wire plain_we     = do_write && !wr_reject && !sw_busy;

    wire irq_clr_we   = plain_we && (wr_idx == `IDX_IRQ_ENABLE_CLR) && lane0;
    wire irq_set_we   = plain_we && (wr_idx == `IDX_IRQ_ENABLE_SET) && lane0;
    wire trig_we      = plain_we && (wr_idx == `IDX_SOFTWARE_TRIGGER) && lane0;

    ////////////////////////////////////////////////////////////////////////////
    // Read decode
    wire ar_take      = arvalid && arready;
    wire nxt_rvalid   = ar_take || (rvalid && !rready);
    wire sigma_delta_pkg::reg_index_t rd_idx = araddr[7:2];
    wire [31:0] rd_value =
        (rd_idx == `IDX_CONTROL_A)      ? {24'h00_0000, ctrl_a_ff} :
        (rd_idx == `IDX_IRQ_ENABLE_CLR) ? {29'h0000_0000, irq_enable_ff} :
        (rd_idx == `IDX_IRQ_ENABLE_SET) ? {29'h0000_0000, irq_enable_ff} :
        (rd_idx == `IDX_SYNC_BUSY)      ? {30'h0000_0000, en_busy, sw_busy} :
        (rd_idx == `IDX_RESULT)         ? conversion_result :
                                          word_ff[rd_idx];

    ////////////////////////////////////////////////////////////////////////////
    // Event inputs: optional inversion, rising edge, per-input enable
    wire [31:0] ev_ctrl    = word_ff[`IDX_EVENT_CONTROL];
    wire        start_lvl  = start_event ^ ev_ctrl[`EV_START_INV];
    wire        flush_lvl  = flush_event ^ ev_ctrl[`EV_FLUSH_INV];
    wire        start_edge = start_lvl && !start_prev_ff && ev_ctrl[`EV_START_EN];
    wire        flush_edge = flush_lvl && !flush_prev_ff && ev_ctrl[`EV_FLUSH_EN];
    wire        any_flush  = flush_edge || (trig_we && wdata_ff[`TRIG_FLUSH]);
    // Flush outranks a simultaneous start
    wire        any_start  = !any_flush && (start_edge || (trig_we && wdata_ff[`TRIG_START]));

    ////////////////////////////////////////////////////////////////////////////
    // Bus channel registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            awready    <= 1'b0;
            wready     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= `RESP_OKAY;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awready    <= !nxt_aw_held;
            wready     <= !nxt_w_held;
            bvalid     <= nxt_bvalid;
            if (aw_take)
                awaddr_ff <= awaddr;
            if (w_take) begin
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (do_write)
                bresp <= wr_reject ? `RESP_SLVERR : `RESP_OKAY;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else begin
            arready <= !nxt_rvalid;
            rvalid  <= nxt_rvalid;
            rresp   <= `RESP_OKAY;
            if (ar_take)
                rdata <= rd_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control A; on-request and run-in-standby act without a handshake
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sw_done) begin
            ctrl_a_ff <= `CONTROL_A_RESET;
        end else if (start_sw) begin
            ctrl_a_ff[`CA_SOFT_RESET] <= 1'b1;
        end else if (ctrl_a_plain) begin
            ctrl_a_ff[`CA_ON_REQUEST]  <= wdata_ff[`CA_ON_REQUEST];
            ctrl_a_ff[`CA_RUN_STANDBY] <= wdata_ff[`CA_RUN_STANDBY];
            ctrl_a_ff[`CA_ENABLE]      <= wdata_ff[`CA_ENABLE];
        end
    end

    // Converter only sees the enable once synchronisation completes
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sw_done)
            enabled_synced_ff <= 1'b0;
        else if (en_done)
            enabled_synced_ff <= ctrl_a_ff[`CA_ENABLE];
    end

    // Set and clear share one enable mask; a write of one sets or clears
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sw_done)
            irq_enable_ff <= 3'h0;
        else if (irq_set_we)
            irq_enable_ff <= irq_enable_ff | (wdata_ff[2:0] & 3'(`MASK_IRQ_ENABLE));
        else if (irq_clr_we)
            irq_enable_ff <= irq_enable_ff & ~(wdata_ff[2:0] & 3'(`MASK_IRQ_ENABLE));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Plain storage words; reserved bits never take a one
    genvar gi;
    generate
        for (gi = 0; gi < 64; gi = gi + 1) begin : g_word
            wire [31:0] bit_we = wr_mask(6'(gi)) & strb_mask;
            wire        hit    = plain_we && (wr_idx == 6'(gi));
            always_ff @(posedge ref_clk) begin
                if (!rst_n || sw_done)
                    word_ff[gi] <= reset_value(6'(gi));
                else if (hit)
                    word_ff[gi] <= (word_ff[gi] & ~bit_we) | (wdata_ff & bit_we);
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Triggers and reference outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            start_prev_ff       <= 1'b0;
            flush_prev_ff       <= 1'b0;
            conversion_start    <= 1'b0;
            conversion_flush    <= 1'b0;
            reference_buffer_on <= 1'b0;
            reference_select    <= 2'b00;
        end else begin
            start_prev_ff       <= start_lvl;
            flush_prev_ff       <= flush_lvl;
            conversion_start    <= any_start;
            conversion_flush    <= any_flush;
            reference_buffer_on <= word_ff[`IDX_REFERENCE_CTRL][`RC_BUFFER_ON];
            reference_select    <= word_ff[`IDX_REFERENCE_CTRL][`RC_SELECT_HI:`RC_SELECT_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync trackers stand outside the soft reset so their flags survive it
    sync_tracker u_soft_reset_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (start_sw),
        .busy_ff (sw_busy),
        .done_ff (sw_done)
    );

    sync_tracker u_enable_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (start_en),
        .busy_ff (en_busy),
        .done_ff (en_done)
    );

    // A start trigger counts as a request so on-request mode wakes on it
    converter_run_control u_run_control (
        .ref_clk                 (ref_clk),
        .rst_n                   (rst_n && !sw_done),
        .enabled                 (enabled_synced_ff),
        .on_request_mode         (ctrl_a_ff[`CA_ON_REQUEST]),
        .keep_running_in_standby (ctrl_a_ff[`CA_RUN_STANDBY]),
        .standby_sleep           (standby_sleep),
        .conv_request            (conv_request || any_start),
        .conv_done               (conv_done),
        .analog_on_ff            (analog_powered),
        .running_ff              (converter_running)
    );

endmodule : sigma_delta_adc_control_regs

/* File: dv/conv_engine.sv */
// Behavioural conversion engine on the far side of the run control.
// Assumes converter_running is synchronous to ref_clk.
`timescale 1ns/10ps
module conv_engine (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic converter_running,
    output logic      conv_done
);
    logic [3:0] count_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !converter_running) count_ff <= 4'h0;
        else count_ff <= count_ff + 4'h1;
    end
    // One pulse per 16 running cycles, none after the first halted cycle
    assign conv_done = (count_ff == 4'hf);
endmodule : conv_engine

/* File: dv/adc_regs_monitor.sv */
// Bus and run-control checker for the converter register front end.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module adc_monitor (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        analog_powered,
    input wire logic        converter_running
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    b_drop_a: assert property (bvalid && bready |=> !bvalid) else $error("write answer repeated");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
    rresp_okay_a: assert property (rvalid |-> rresp == 2'b00) else $error("read response not okay");
    write_answer_a: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write answer late");
    read_answer_a: assert property (arvalid && arready |=> ##[0:1] rvalid) else $error("read answer late");
    run_powered_a: assert property (converter_running |-> analog_powered) else $error("running unpowered");
    startup_wait_a: assert property ($rose(converter_running) |-> $past(analog_powered, 40))
        else $error("start-up too short");
    // Reset must be seen even though the other checks are gated by it
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !analog_powered && !converter_running)
        else $error("outputs active after reset");
    run_rise_c: cover property ($rose(converter_running));
    power_fall_c: cover property ($fell(analog_powered));
    read_stall_c: cover property (rvalid && !rready);
endmodule : adc_monitor
bind sigma_delta_adc_control_regs adc_monitor u_mon (.ref_clk, .rst_n, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .analog_powered, .converter_running);

/* File: dv/tb.sv */
// Self-checking bench for the converter register front end.
// Assumes the params header is on the include path; bready is held high throughout.
`timescale 1ns/10ps
`include "sigma_delta_params.svh"
module tb;
    logic        ref_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 0;
    logic        standby_sleep = 0, conv_request = 0, start_event = 0, flush_event = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [3:0]  wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, conversion_result = 32'h0, seed = 32'd12335, rnd;
    logic        awready, wready, bvalid, arready, rvalid, conv_done, analog_powered, converter_running;
    logic        conversion_start, conversion_flush, reference_buffer_on;
    logic [1:0]  bresp, rresp, reference_select;
    logic [31:0] rdata;
    logic [31:0] exp_r[$];
    logic [1:0]  exp_b[$];
    int          failures = 0, total_checks = 0;
    sigma_delta_adc_control_regs u_dut (.ref_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .standby_sleep, .conv_request, .conv_done, .conversion_result, .start_event, .flush_event, .analog_powered,
        .converter_running, .conversion_start, .conversion_flush, .reference_buffer_on, .reference_select);
    conv_engine u_eng (.ref_clk, .rst_n, .converter_running, .conv_done);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        if (failures == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    always @(posedge ref_clk) begin
        if (rvalid && rready) chk(rdata, exp_r.pop_front());
        if (bvalid && bready) chk({30'h0, bresp}, {30'h0, exp_b.pop_front()});
    end
    task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] r);
        logic a;
        logic w;
        exp_b.push_back(r);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        a = 1'b1;
        w = 1'b1;
        while (a || w) begin
            @(posedge ref_clk);
            if (a && awready) begin
                a = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!bvalid);
    endtask : wr
    // Read data is left waiting one edge so the hold behaviour is exercised
    task automatic rd(input logic [5:0] idx, input logic [31:0] e);
        exp_r.push_back(e);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        @(posedge ref_clk);
        rready <= 1'b1;
        do @(posedge ref_clk); while (!rvalid);
        rready <= 0;
    endtask : rd
    // Synchronised write, a second one while busy, and a busy-flag read in flight
    task automatic sync_op(input logic [31:0] d, input logic [31:0] busy);
        fork
            begin
                wr(`IDX_CONTROL_A, d, `RESP_OKAY);
                wr(`IDX_CONTROL_A, d ^ 32'h2, `RESP_SLVERR);
            end
            begin
                repeat (2) @(posedge ref_clk);
                rd(`IDX_SYNC_BUSY, busy);
            end
        join
    endtask : sync_op
    initial forever #20 ref_clk = ~ref_clk;
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        conversion_result <= xs();
        rnd = xs();
        repeat (2) @(posedge ref_clk);
        rd(`IDX_CONTROL_A, 32'h0);
        rd(`IDX_REFERENCE_CTRL, 32'h0);
        rd(6'h03, 32'h0);
        rd(`IDX_RESULT, conversion_result);
        wr(`IDX_CONTROL_B, rnd, `RESP_OKAY);
        rd(`IDX_CONTROL_B, rnd & `MASK_CONTROL_B);
        wr(`IDX_CONTROL_A, 32'hc0, `RESP_OKAY);
        rd(`IDX_CONTROL_A, 32'hc0);
        sync_op(32'hc2, 32'h2);
        rd(`IDX_CONTROL_A, 32'hc2);
        wr(`IDX_REFERENCE_CTRL, 32'h83, `RESP_SLVERR);
        repeat (60) @(posedge ref_clk);
        chk({31'h0, analog_powered}, 32'h0);
        conv_request <= 1'b1;
        repeat (60) @(posedge ref_clk);
        chk({31'h0, converter_running}, 32'h1);
        conv_request <= 1'b0;
        repeat (24) @(posedge ref_clk);
        chk({31'h0, analog_powered}, 32'h0);
        wr(`IDX_CONTROL_A, 32'h02, `RESP_OKAY);
        repeat (60) @(posedge ref_clk);
        chk({31'h0, converter_running}, 32'h1);
        standby_sleep <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({31'h0, converter_running}, 32'h0);
        wr(`IDX_CONTROL_A, 32'h42, `RESP_OKAY);
        repeat (60) @(posedge ref_clk);
        chk({31'h0, converter_running}, 32'h1);
        standby_sleep <= 1'b0;
        wr(`IDX_CONTROL_A, 32'h40, `RESP_OKAY);
        repeat (8) @(posedge ref_clk);
        chk({31'h0, converter_running}, 32'h0);
        wr(`IDX_REFERENCE_CTRL, 32'hff, `RESP_OKAY);
        rd(`IDX_REFERENCE_CTRL, 32'h83);
        chk({29'h0, reference_buffer_on, reference_select}, 32'h7);
        // Both event inputs enabled; a simultaneous edge must give flush only
        wr(`IDX_EVENT_CONTROL, 32'h3, `RESP_OKAY);
        start_event <= 1'b1;
        flush_event <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({30'h0, conversion_start, conversion_flush}, 32'h1);
        @(posedge ref_clk);
        start_event <= 1'b0;
        flush_event <= 1'b0;
        @(posedge ref_clk);
        start_event <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({30'h0, conversion_start, conversion_flush}, 32'h2);
        @(posedge ref_clk);
        start_event <= 1'b0;
        sync_op(32'hc3, 32'h1);
        repeat (8) @(posedge ref_clk);
        rd(`IDX_CONTROL_A, 32'h0);
        rd(`IDX_REFERENCE_CTRL, 32'h0);
        rd(`IDX_CONTROL_B, `RESET_CONTROL_B);
        rd(`IDX_SYNC_BUSY, 32'h0);
        conclude();
    end
endmodule : tb
